// file: rtl/rne_regs.vh
/*
  Constants of the reset / NMI exception-entry block: register offsets,
  field positions, reset values and vector constants.
  Assumes it is included by bare name from the block's design file.
*/
`ifndef RNE_REGS_VH
`define RNE_REGS_VH


// register byte offsets
`define RNE_OFS_STATUS 8'h00
`define RNE_OFS_CONFIG 8'h04
`define RNE_OFS_ERRPC  8'h08
`define RNE_OFS_WATCH  8'h0C
`define RNE_OFS_PERF   8'h10
`define RNE_OFS_PAGE   8'h14
`define RNE_OFS_EVENT  8'h18

// status field positions and reset value
`define RNE_ST_ERRLVL 0
`define RNE_ST_NMI    1
`define RNE_ST_SOFT   2
`define RNE_ST_SHUT   3
`define RNE_ST_BOOTV  4
`define RNE_ST_PWR    5
`define RNE_ST_RESET 6'h11

// config field positions
`define RNE_CF_CA   0
`define RNE_CF_ISA  1
`define RNE_CF_MMAR 3
`define RNE_CF_K0   5

// page field positions
`define RNE_PG_MASKX 0
`define RNE_PG_ESP   1
`define RNE_PG_VPN2X 2

// vectors, adjustments and encodings
`define RNE_RESET_VECTOR 32'hBFC00000
`define RNE_ADJ_WORD     3'h4
`define RNE_ADJ_HALF     3'h2
`define RNE_ADJ_NONE     3'h0
`define RNE_ARCH_VARLEN  2'h3
`define RNE_ISA_FIXED    2'h0
`define RNE_ISA_VARONLY  2'h1
`define RNE_ISA_MODE1    2'h3
`define RNE_K0_SUGGESTED 3'h2

`endif

// file: rtl/rne_entry.v
/*
  Exception entry for cold reset, soft reset and non-maskable interrupt:
  status fields, watch / perf enables, resume pc and delay slot fixup,
  error return pc, isa mode and the jump to the reset vector, plus an
  APB slave for the state it owns.
  Assumes the three event pins are asynchronous to clk, the core-side
  inputs are on clk, and the core acts on pcLoad / coreAbort at once.
*/
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "rne_regs.vh"

module rne_entry #(
  parameter SOFT_RESET_IMPL = 1,
  parameter NMI_IMPL        = 1,
  parameter SMALL_PAGE_IMPL = 1,
  parameter K0_ON_SOFT      = 1,
  parameter NUM_WATCH       = 4,
  parameter NUM_PERF        = 2,
  parameter [7:0] BOOT_CONFIG = 8'h00
)(
  input  wire                   clk,
  input  wire                   nrst,
  input  wire                   coldResetPin,
  input  wire                   softResetPin,
  input  wire                   nmiPin,
  input  wire                   instrBoundary,
  input  wire [31:0]            curPc,
  input  wire                   curIsaMode,
  input  wire                   extendedInstr,
  input  wire                   inDelaySlot,
  input  wire [2:0]             delaySlotInstrSize,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [7:0]             paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  output reg                    pcLoad,
  output reg  [31:0]            pcTarget,
  output reg                    isaModeBit,
  output reg                    coreAbort,
  output reg  [31:0]            errorReturnPc,
  output reg  [5:0]             statusFlags,
  output reg  [3*NUM_WATCH-1:0] watchEnables,
  output reg  [NUM_PERF-1:0]    perfIrqEnables
);

  localparam WW = 3 * NUM_WATCH;

  // ***********************************************
  // pin synchronisers and event detection
  // ***********************************************

  reg  [2:0] pinMeta_r;
  reg  [2:0] pinSync_r;
  reg  [2:0] pinPrev_r;
  wire       coldLvl;
  wire       softLvl;
  wire       nmiLvl;
  wire       coldEvt;
  wire       softEvt;
  wire       nmiEvt;
  reg        nmiPend_r;
  reg        nmiPend_nxt;
  wire       nmiTake;
  wire       doCold;
  wire       doSoft;
  wire       anyEvt;

  // two flops before any logic sees the pins
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pinMeta_r <= 3'h0;
      pinSync_r <= 3'h0;
      pinPrev_r <= 3'h0;
    end
    else
    begin
      pinMeta_r <= {nmiPin, softResetPin, coldResetPin};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  assign coldLvl = pinSync_r[0];
  assign softLvl = pinSync_r[1];
  assign nmiLvl  = pinSync_r[2];
  assign coldEvt = coldLvl & ~pinPrev_r[0];
  assign softEvt = softLvl & ~pinPrev_r[1];
  assign nmiEvt  = (NMI_IMPL != 0) & nmiLvl & ~pinPrev_r[2];

  // soft reset falls back to a cold reset when not supported
  assign doCold = coldEvt | (softEvt & (SOFT_RESET_IMPL == 0));
  // cold wins over soft, soft over the interrupt
  assign doSoft = softEvt & ~doCold & (SOFT_RESET_IMPL != 0);
  // the interrupt is only taken at an instruction boundary
  assign nmiTake = (nmiEvt | nmiPend_r) & instrBoundary & ~doCold & ~doSoft;
  assign anyEvt = doCold | doSoft | nmiTake;

  // a pending interrupt is dropped by either reset, which subsumes it
  always @*
  begin
    nmiPend_nxt = nmiPend_r;
    if (doCold | doSoft)
    begin
      nmiPend_nxt = 1'b0;
    end
    else if (nmiEvt & ~instrBoundary)
    begin
      nmiPend_nxt = 1'b1;
    end
    else if (nmiTake)
    begin
      nmiPend_nxt = 1'b0;
    end
  end

  // ***********************************************
  // resume pc and delay slot adjustment
  // ***********************************************

  reg  [7:0]  cfg_r;
  wire        cfgCa;
  wire [1:0]  cfgIsa;
  wire [1:0]  cfgArch;
  reg  [31:0] resumePc;
  reg  [2:0]  slotAdjust;
  reg         isa_mode_bit_nxt;
  wire        inSlot;
  wire [31:0] entryPc;

  assign cfgCa   = cfg_r[`RNE_CF_CA];
  assign cfgIsa  = cfg_r[`RNE_CF_ISA +: 2];
  assign cfgArch = cfg_r[`RNE_CF_MMAR +: 2];

  // pick resume point and fixup per instruction-set configuration
  always @*
  begin
    resumePc    = curPc;
    slotAdjust  = `RNE_ADJ_WORD;
    isa_mode_bit_nxt = curIsaMode;
    if (!cfgCa && (cfgIsa == `RNE_ISA_FIXED))
    begin
      resumePc   = curPc;
      slotAdjust = `RNE_ADJ_WORD;
    end
    else if (cfgCa)
    begin
      resumePc = {curPc[31:1], curIsaMode};
      if (!curIsaMode || extendedInstr)
      begin
        slotAdjust = `RNE_ADJ_WORD;
      end
      else
      begin
        slotAdjust = `RNE_ADJ_HALF;
      end
      isa_mode_bit_nxt = 1'b0;
    end
    else if (cfgIsa == `RNE_ISA_VARONLY)
    begin
      resumePc = curPc;
      if (cfgArch == `RNE_ARCH_VARLEN)
      begin
        slotAdjust = `RNE_ADJ_NONE;
      end
      else
      begin
        slotAdjust = delaySlotInstrSize;
      end
    end
    else
    begin
      resumePc = {curPc[31:1], curIsaMode};
      if (!curIsaMode)
      begin
        slotAdjust = `RNE_ADJ_WORD;
      end
      else
      begin
        slotAdjust = delaySlotInstrSize;
      end
      isa_mode_bit_nxt = (cfgIsa == `RNE_ISA_MODE1);
    end
  end

  // variable-length revision never reports a delay slot
  assign inSlot = inDelaySlot & (cfgArch != `RNE_ARCH_VARLEN);
  assign entryPc = inSlot ? (resumePc - {29'h0, slotAdjust}) : resumePc;

  // ***********************************************
  // APB slave
  // ***********************************************

  reg  [5:0]    status_r;
  reg  [31:0]   errPc_r;
  reg  [WW-1:0] watch_r;
  reg  [NUM_PERF-1:0] perf_r;
  reg  [2:0]    page_r;
  reg  [3:0]    evt_r;
  wire          apbAccess;
  wire          apbWrite;
  reg  [31:0]   rdMux;
  reg           rdErr;

  // one wait state: pready rises one edge into the access phase
  assign apbAccess = psel & penable & ~pready;
  assign apbWrite  = psel & penable & pready & pwrite;

  // read decode; unmapped offsets answer with an error
  always @*
  begin
    rdMux = 32'h00000000;
    rdErr = 1'b0;
    if (paddr == `RNE_OFS_STATUS)
    begin
      rdMux = {26'h0, status_r};
    end
    else if (paddr == `RNE_OFS_CONFIG)
    begin
      rdMux = {24'h0, cfg_r};
    end
    else if (paddr == `RNE_OFS_ERRPC)
    begin
      rdMux = errPc_r;
    end
    else if (paddr == `RNE_OFS_WATCH)
    begin
      rdMux[WW-1:0] = watch_r;
    end
    else if (paddr == `RNE_OFS_PERF)
    begin
      rdMux[NUM_PERF-1:0] = perf_r;
    end
    else if (paddr == `RNE_OFS_PAGE)
    begin
      rdMux = {29'h0, page_r};
    end
    else if (paddr == `RNE_OFS_EVENT)
    begin
      rdMux = {28'h0, evt_r};
    end
    else
    begin
      rdErr = 1'b1;
    end
  end

  function isSel;
    input [7:0] ofs;
    begin
      isSel = apbWrite & (paddr == ofs);
    end
  endfunction

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apbAccess;
      prdata  <= apbAccess ? rdMux : 32'h00000000;
      pslverr <= apbAccess & rdErr;
    end
  end

  // ***********************************************
  // architectural state: events win over software writes
  // ***********************************************

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_r  <= `RNE_ST_RESET;
      cfg_r     <= BOOT_CONFIG;
      errPc_r   <= 32'h00000000;
      watch_r   <= {WW{1'b0}};
      perf_r    <= {NUM_PERF{1'b0}};
      page_r    <= 3'h0;
      evt_r     <= 4'h0;
      nmiPend_r <= 1'b0;
    end
    else
    begin
      nmiPend_r <= nmiPend_nxt;
      evt_r <= {nmiPend_nxt, nmiTake, doSoft, doCold};
      if (doCold)
      begin
        // full init; boot configuration reloaded with K0 forced to the suggested value
        status_r <= `RNE_ST_RESET;
        cfg_r    <= {`RNE_K0_SUGGESTED, BOOT_CONFIG[4:0]};
        errPc_r  <= entryPc;
        watch_r  <= {WW{1'b0}};
        perf_r   <= {NUM_PERF{1'b0}};
        page_r   <= 3'h0;
      end
      else if (doSoft)
      begin
        status_r <= 6'h15;
        if (K0_ON_SOFT != 0)
        begin
          cfg_r[`RNE_CF_K0 +: 3] <= `RNE_K0_SUGGESTED;
        end
        errPc_r <= entryPc;
        watch_r <= {WW{1'b0}};
        perf_r  <= {NUM_PERF{1'b0}};
        if (SMALL_PAGE_IMPL != 0)
        begin
          page_r <= 3'h0;
        end
      end
      else if (nmiTake)
      begin
        // power flag kept; other fields forced
        status_r <= {status_r[`RNE_ST_PWR], 5'h13};
        errPc_r  <= entryPc;
      end
      else
      begin
        if (isSel(`RNE_OFS_STATUS))
        begin
          status_r <= pwdata[5:0];
        end
        if (isSel(`RNE_OFS_CONFIG))
        begin
          cfg_r <= pwdata[7:0];
        end
        if (isSel(`RNE_OFS_ERRPC))
        begin
          errPc_r <= pwdata;
        end
        if (isSel(`RNE_OFS_WATCH))
        begin
          watch_r <= pwdata[WW-1:0];
        end
        if (isSel(`RNE_OFS_PERF))
        begin
          perf_r <= pwdata[NUM_PERF-1:0];
        end
        if (isSel(`RNE_OFS_PAGE) && (SMALL_PAGE_IMPL != 0))
        begin
          page_r <= pwdata[2:0];
        end
      end
    end
  end

  // ***********************************************
  // core-facing outputs
  // ***********************************************

  // every output is a flop; pcLoad is the one-cycle jump strobe
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pcLoad     <= 1'b0;
      pcTarget   <= `RNE_RESET_VECTOR;
      isaModeBit <= 1'b0;
      coreAbort  <= 1'b0;
    end
    else
    begin
      pcLoad   <= anyEvt;
      pcTarget <= `RNE_RESET_VECTOR;
      if (anyEvt)
      begin
        isaModeBit <= isa_mode_bit_nxt;
      end
      else
      begin
        isaModeBit <= curIsaMode;
      end
      // abort held with either reset pin; in-flight bus/cache work is cut
      coreAbort <= coldLvl | (softLvl & (SOFT_RESET_IMPL != 0)) | doCold | doSoft;
    end
  end

  // mirror of the status, errpc, watch and perf registers, one cycle behind them
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      errorReturnPc  <= 32'h00000000;
      statusFlags    <= `RNE_ST_RESET;
      watchEnables   <= {WW{1'b0}};
      perfIrqEnables <= {NUM_PERF{1'b0}};
    end
    else
    begin
      errorReturnPc  <= errPc_r;
      statusFlags    <= status_r;
      watchEnables   <= watch_r;
      perfIrqEnables <= perf_r;
    end
  end

endmodule

// file: test/rne_pins.sv
/*
  System-side model of the reset and nmi pins of the entry block.
  Assumes the bench pulses fireMask for one cycle; bit0 cold, bit1 soft, bit2 nmi.
*/
`timescale 1ns/1ps
module rne_pins (
  input  wire       clk,
  input  wire [2:0] fireMask,
  output reg        coldResetPin,
  output reg        softResetPin,
  output reg        nmiPin
);
  reg [2:0] holdCnt;
  initial
  begin
    holdCnt = 3'h0;
    {nmiPin, softResetPin, coldResetPin} = 3'h0;
  end
  // pins stay high long enough for the two-flop sync, then drop low
  always @(posedge clk)
  begin
    if (fireMask != 3'h0)
    begin
      {nmiPin, softResetPin, coldResetPin} <= fireMask;
      holdCnt <= 3'h6;
    end
    else if (holdCnt != 3'h0)
      holdCnt <= holdCnt - 3'h1;
    else
      {nmiPin, softResetPin, coldResetPin} <= 3'h0;
  end
endmodule

// file: test/rne_entry_sva.sv
/*
  Port checker for the exception entry block.
  Assumes bind onto rne_entry; pins driven synchronously by the bench.
*/
`timescale 1ns/1ps
module rne_entry_sva #(
  parameter NUM_WATCH = 4,
  parameter NUM_PERF  = 2
)(
  input wire                   clk,
  input wire                   nrst,
  input wire                   coldResetPin,
  input wire                   softResetPin,
  input wire                   instrBoundary,
  input wire                   psel,
  input wire                   penable,
  input wire                   pready,
  input wire                   pslverr,
  input wire                   pcLoad,
  input wire [31:0]            pcTarget,
  input wire                   coreAbort,
  input wire [5:0]             statusFlags,
  input wire [3*NUM_WATCH-1:0] watchEnables,
  input wire [NUM_PERF-1:0]    perfIrqEnables
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // nmi entries are the only ones taken with coreAbort low
  vec_fixed_a: assert property (pcTarget == 32'hBFC00000)
    else $error("jump target is not the reset vector");
  pc_pulse_a: assert property (pcLoad |=> !pcLoad)
    else $error("pcLoad wider than one cycle");
  soft_entry_a: assert property ($rose(softResetPin) && !coldResetPin |-> ##[2:5] pcLoad)
    else $error("soft reset not taken");
  soft_flags_a: assert property ($rose(softResetPin) && !coldResetPin |-> ##[3:6] statusFlags == 6'h15)
    else $error("soft reset flags wrong");
  nmi_flags_a: assert property (pcLoad && !coreAbort |=>
    statusFlags[4:0] == 5'h13 && statusFlags[5] == $past(statusFlags[5]))
    else $error("nmi flags wrong");
  nmi_boundary_a: assert property (pcLoad && !coreAbort |-> $past(instrBoundary))
    else $error("nmi taken off a boundary");
  reset_clear_a: assert property (pcLoad && coreAbort |=> watchEnables == '0 && perfIrqEnables == '0)
    else $error("enables not cleared on reset entry");
  abort_hold_a: assert property (coldResetPin [*5] |-> coreAbort)
    else $error("core not aborted under cold reset");
  apb_ready_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  cover property (pcLoad && coreAbort);
  cover property (pcLoad && !coreAbort);
  cover property (pslverr);
endmodule
bind rne_entry rne_entry_sva #(.NUM_WATCH(NUM_WATCH), .NUM_PERF(NUM_PERF)) chk (
  .clk, .nrst, .coldResetPin, .softResetPin, .instrBoundary, .psel, .penable, .pready,
  .pslverr, .pcLoad, .pcTarget, .coreAbort, .statusFlags, .watchEnables, .perfIrqEnables);

// file: test/testbench.sv
/*
  Self-checking bench for the exception entry block: a table of events, then hand tests.
  Assumes rne_entry with default parameters and the rne_pins model on its pins.
*/
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [7:0]  cfg;
    logic [31:0] pc;
    logic        mode, ext, ds;
    logic [2:0]  sz, kind;
  } rne_row_t;
  logic        clk, nrst, coldResetPin, softResetPin, nmiPin, instrBoundary;
  logic        curIsaMode, extendedInstr, inDelaySlot, psel, penable, pwrite;
  logic        pready, pslverr, pcLoad, isaModeBit, coreAbort, err, nmiE;
  logic [2:0]  delaySlotInstrSize, fireMask;
  logic [7:0]  paddr;
  logic [31:0] curPc, pwdata, prdata, pcTarget, errorReturnPc, rd;
  logic [5:0]  statusFlags;
  logic [11:0] watchEnables;
  logic [1:0]  perfIrqEnables;
  int          mismatches, compares, cycles;
  rne_row_t    r;
  rne_row_t    rows[9] = '{
    '{8'h00, 32'h10000010, 1'b0, 1'b0, 1'b1, 3'h4, 3'h1},
    '{8'h01, 32'h20000006, 1'b1, 1'b0, 1'b1, 3'h2, 3'h2},
    '{8'h01, 32'h20000006, 1'b1, 1'b1, 1'b1, 3'h4, 3'h4},
    '{8'h02, 32'h30000008, 1'b1, 1'b0, 1'b1, 3'h2, 3'h2},
    '{8'h1A, 32'h30000008, 1'b1, 1'b0, 1'b1, 3'h2, 3'h4},
    '{8'h06, 32'h40000010, 1'b1, 1'b0, 1'b1, 3'h4, 3'h2},
    '{8'h04, 32'h40000020, 1'b0, 1'b0, 1'b1, 3'h2, 3'h4},
    '{8'h04, 32'h50000004, 1'b1, 1'b0, 1'b0, 3'h2, 3'h1},
    '{8'h00, 32'h60000000, 1'b0, 1'b0, 1'b0, 3'h4, 3'h2}};

  rne_entry uut (.clk, .nrst, .coldResetPin, .softResetPin, .nmiPin, .instrBoundary, .curPc,
    .curIsaMode, .extendedInstr, .inDelaySlot, .delaySlotInstrSize, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pcLoad, .pcTarget, .isaModeBit, .coreAbort,
    .errorReturnPc, .statusFlags, .watchEnables, .perfIrqEnables);
  rne_pins pins (.clk, .fireMask, .coldResetPin, .softResetPin, .nmiPin);

  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] expPc(input rne_row_t x);
    logic [31:0] rs;
    logic [2:0]  adj;
    begin
      rs = x.pc;
      adj = 3'h4;
      if (x.cfg[0])
      begin
        rs = {x.pc[31:1], x.mode};
        adj = (!x.mode || x.ext) ? 3'h4 : 3'h2;
      end
      else if (x.cfg[2:1] == 2'h1)
        adj = (x.cfg[4:3] == 2'h3) ? 3'h0 : x.sz;
      else if (x.cfg[2:1] != 2'h0)
      begin
        rs = {x.pc[31:1], x.mode};
        adj = x.mode ? x.sz : 3'h4;
      end
      // revision 3 never sits in a delay slot
      expPc = (x.ds && x.cfg[4:3] != 2'h3) ? rs - {29'h0, adj} : rs;
    end
  endfunction

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      compares++;
      if (g !== e)
      begin
        mismatches++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task fire(input logic [2:0] m);
    int n;
    begin
      n = 0;
      @(posedge clk);
      fireMask <= m;
      @(posedge clk);
      fireMask <= 3'h0;
      while (pcLoad !== 1'b1 && ++n < 40)
        @(posedge clk);
    end
  endtask

  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard: the run needs well under 3000 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      mismatches++;
      close_out;
    end
  end

  // ********************
  // main sequence
  // ********************
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata, fireMask} = '0;
    {curPc, curIsaMode, extendedInstr, inDelaySlot, delaySlotInstrSize} = '0;
    instrBoundary = 1'b1;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      r = rows[i];
      nmiE = r.kind[2];
      apb(1'b1, 8'h04, {24'h0, r.cfg});
      apb(1'b1, 8'h0C, 32'hFFF);
      apb(1'b1, 8'h10, 32'h3);
      apb(1'b1, 8'h14, 32'h7);
      curPc <= r.pc;
      curIsaMode <= r.mode;
      extendedInstr <= r.ext;
      inDelaySlot <= r.ds;
      delaySlotInstrSize <= r.sz;
      fire(r.kind);
      chk("pcLoad", 1, pcLoad);
      chk("isa_mode_bit", r.cfg[0] ? 0 : r.cfg[2:1] > 1 ? r.cfg[2:1] == 3 : r.mode, isaModeBit);
      @(posedge clk);
      chk("status", nmiE ? 32'h13 : r.kind[0] ? 32'h11 : 32'h15, statusFlags);
      chk("errpc", expPc(r), errorReturnPc);
      chk("watch", nmiE ? 32'hFFF : 0, watchEnables);
      chk("perf", nmiE ? 32'h3 : 0, perfIrqEnables);
      apb(1'b0, 8'h14, 0);
      chk("page", nmiE ? 32'h7 : 0, rd);
      apb(1'b0, 8'h04, 0);
      chk("config", nmiE ? r.cfg : r.kind[0] ? 32'h40 : {3'h2, r.cfg[4:0]}, rd);
      $display("row %0d done", i);
    end
    // all three at once: cold wins
    fire(3'h7);
    @(posedge clk);
    chk("priority", 32'h11, statusFlags);
    $display("priority done");
    // nmi held off until a boundary, power flag kept
    apb(1'b1, 8'h00, 32'h20);
    instrBoundary <= 1'b0;
    fire(3'h4);
    chk("pending", 0, pcLoad);
    instrBoundary <= 1'b1;
    while (pcLoad !== 1'b1 && cycles < 5000)
      @(posedge clk);
    @(posedge clk);
    chk("nmiPower", 32'h33, statusFlags);
    $display("pending nmi done");
    // unmapped offset is refused
    apb(1'b1, 8'h1C, 32'hFFFFFFFF);
    chk("slverr", 1, err);
    apb(1'b0, 8'h1C, 0);
    chk("unmapped", 0, rd);
    $display("unmapped done");
    close_out;
  end
endmodule
